// ===== design/twdc_pkg.sv
// Constants for the two-wire run and direction decoder.
// Assumes a 32-bit Avalon-MM slave port addressed by bytes.
package twdc_pkg;
    localparam logic [4:0] TWDC_OFS_CMD_SRC = 5'h00;
    localparam logic [4:0] TWDC_OFS_WIRE = 5'h04;
    localparam logic [4:0] TWDC_OFS_STATUS = 5'h08;
    localparam logic [4:0] TWDC_OFS_FN0 = 5'h10;
    localparam logic [4:0] TWDC_OFS_STEP = 5'h04;
    localparam logic [7:0] TWDC_CMD_SRC_RST = 8'h02;
    localparam logic [7:0] TWDC_WIRE_RST = 8'h00;
    localparam logic [31:0] TWDC_FN_RST = 32'h0000_0C01;
    localparam logic [7:0] TWDC_SRC_DIN = 8'h02;
    localparam logic [7:0] TWDC_WIRE_TWO = 8'h00;
    localparam logic [7:0] TWDC_FN_RUN = 8'h01;
    localparam logic [7:0] TWDC_FN_CCW = 8'h02;
    localparam logic [7:0] TWDC_FN_REV = 8'h0C;
    localparam int TWDC_NUM_DIN = 4;
    localparam int TWDC_ST_POS = 4;
    localparam int TWDC_DIN_POS = 8;
    localparam int TWDC_M2_POS = 12;
    localparam int TWDC_FIRST_POS = 13;
    typedef enum logic [3:0]
    {
        TWDC_IDLE = 4'h1,
        TWDC_CW = 4'h2,
        TWDC_CCW = 4'h4,
        TWDC_STOP = 4'h8
    } twdc_state_t;
endpackage

// ===== design/twdc_top.sv
// Two-wire run and direction decoder with Avalon-MM registers.
// Assumes din comes from plant pins; at_zero_hz comes from the
// ramp path on sys_clk.
// Function
// - Command source 2 makes the digital inputs the command source.
// - Wire method 0 selects two-wire; input functions pick method 1 or 2.
// - Method 1: run low gives ramp stop, reverse ignored.
// - Method 1: run high runs to setpoint, inverted when reverse high.
// - First input defaults to function 1, run or clockwise run.
// - Function 12 makes an input the method 1 reverse command.
// - Function 2 makes an input the method 2 counter-clockwise run.
// - Any function may be given to any digital input.
// - Method 2: CW runs, CCW runs inverted, neither gives ramp stop.
// - Method 2: direction change only after ramp stop reaches 0 Hz.
// - Method 2: both high, the first active command keeps control.
// - Clockwise request gives a clockwise output phase sequence; no phase output here, clockwise only keeps setpoint_invert low.
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module twdc_top
    import twdc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [3:0] din,
    input wire logic at_zero_hz,
    output logic run_req,
    output logic setpoint_invert,
    output logic ramp_stop,
    output logic cmd_active
);
    logic [7:0] cmd_src_r;
    logic [7:0] wire_r;
    logic [7:0] fn_r [TWDC_NUM_DIN];
    logic [3:0] din_s1_r;
    logic [3:0] din_s2_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic run_req_r;
    logic run_req_nxt;
    logic inv_r;
    logic inv_nxt;
    logic stop_r;
    logic stop_nxt;
    logic act_r;
    logic first_ccw_r;
    logic first_ccw_nxt;
    twdc_state_t state_r;
    twdc_state_t state_nxt;

    wire wr_take;
    wire rd_load;
    wire [3:0] is_run;
    wire [3:0] is_ccw;
    wire [3:0] is_rev;
    wire [3:0] fn_wr;
    wire [31:0] fn_rd [TWDC_NUM_DIN];
    wire [31:0] status_word;
    wire [31:0] rd_data;
    wire active;
    wire method2;
    wire m2_on;
    wire cmd_run;
    wire cmd_ccw;
    wire cmd_rev;
    wire cw_only;
    wire ccw_only;
    wire both_on;

    // Bus handshake: one wait cycle, then answer
    assign wr_take = avs_write && !wait_r;
    assign rd_load = avs_read && wait_r;

    // Per-input function decode and register write select
    genvar gi;
    generate
        for (gi = 0; gi < TWDC_NUM_DIN; gi++)
        begin : g_din
            localparam logic [4:0] OFS = TWDC_OFS_FN0 + 5'(gi) * TWDC_OFS_STEP;
            assign is_run[gi] = (fn_r[gi] == TWDC_FN_RUN);
            assign is_ccw[gi] = (fn_r[gi] == TWDC_FN_CCW);
            assign is_rev[gi] = (fn_r[gi] == TWDC_FN_REV);
            assign fn_wr[gi] = wr_take && (avs_address == OFS);
            assign fn_rd[gi] = (avs_address == OFS) ? {24'h0, fn_r[gi]} : 32'h0;
            always_ff @(posedge sys_clk or negedge arst_n)
            begin
                if (!arst_n)
                    fn_r[gi] <= TWDC_FN_RST[gi*8 +: 8];
                else if (fn_wr[gi])
                    fn_r[gi] <= avs_writedata[7:0];
            end
        end
    endgenerate

    assign status_word = {18'h0, first_ccw_r, method2, din_s2_r,
                          state_r, act_r, stop_r, inv_r, run_req_r};
    assign rd_data =
        (avs_address == TWDC_OFS_CMD_SRC) ? {24'h0, cmd_src_r} :
        (avs_address == TWDC_OFS_WIRE) ? {24'h0, wire_r} :
        (avs_address == TWDC_OFS_STATUS) ? status_word :
        (fn_rd[0] | fn_rd[1] | fn_rd[2] | fn_rd[3]);

    // Command selection
    assign active = (cmd_src_r == TWDC_SRC_DIN) && (wire_r == TWDC_WIRE_TWO);
    assign method2 = |is_ccw;
    assign m2_on = active && method2;
    assign cmd_run = |(din_s2_r & is_run);
    assign cmd_ccw = |(din_s2_r & is_ccw);
    assign cmd_rev = |(din_s2_r & is_rev);
    assign cw_only = cmd_run && !cmd_ccw;
    assign ccw_only = cmd_ccw && !cmd_run;
    assign both_on = cmd_run && cmd_ccw;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            din_s1_r <= 4'h0;
            din_s2_r <= 4'h0;
        end
        else
        begin
            din_s1_r <= din;
            din_s2_r <= din_s1_r;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end
        else
        begin
            wait_r <= !((avs_read || avs_write) && wait_r);
            if (rd_load)
                rdata_r <= rd_data;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_src_r <= TWDC_CMD_SRC_RST;
            wire_r <= TWDC_WIRE_RST;
        end
        else if (wr_take)
        begin
            if (avs_address == TWDC_OFS_CMD_SRC)
                cmd_src_r <= avs_writedata[7:0];
            if (avs_address == TWDC_OFS_WIRE)
                wire_r <= avs_writedata[7:0];
        end
    end

    // First-active tracking for both-high case
    always_comb
    begin
        first_ccw_nxt = first_ccw_r;
        if (cw_only)
            first_ccw_nxt = 1'b0;
        else if (ccw_only)
            first_ccw_nxt = 1'b1;
    end

    // Method 2 direction state machine
    always_comb
    begin
        state_nxt = state_r;
        if (!m2_on)
            state_nxt = TWDC_IDLE;
        else
        begin
            case (state_r)
                TWDC_IDLE:
                begin
                    if (cw_only)
                        state_nxt = TWDC_CW;
                    else if (ccw_only)
                        state_nxt = TWDC_CCW;
                    else if (both_on)
                        state_nxt = first_ccw_r ? TWDC_CCW : TWDC_CW;
                end
                TWDC_CW:
                begin
                    if (!cmd_run)
                        state_nxt = TWDC_STOP;
                end
                TWDC_CCW:
                begin
                    if (!cmd_ccw)
                        state_nxt = TWDC_STOP;
                end
                TWDC_STOP:
                begin
                    if (at_zero_hz)
                        state_nxt = TWDC_IDLE;
                end
                default:
                    state_nxt = TWDC_IDLE;
            endcase
        end
    end

    // Requests to the ramp and setpoint path
    always_comb
    begin
        run_req_nxt = 1'b0;
        inv_nxt = 1'b0;
        stop_nxt = 1'b0;
        if (active && !method2)
        begin
            run_req_nxt = cmd_run;
            inv_nxt = cmd_run && cmd_rev;
            stop_nxt = !cmd_run;
        end
        else if (m2_on)
        begin
            case (state_nxt)
                TWDC_CW:
                    run_req_nxt = 1'b1;
                TWDC_CCW:
                begin
                    run_req_nxt = 1'b1;
                    inv_nxt = 1'b1;
                end
                TWDC_STOP:
                begin
                    inv_nxt = inv_r;
                    stop_nxt = 1'b1;
                end
                default:
                    stop_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= TWDC_IDLE;
            first_ccw_r <= 1'b0;
            run_req_r <= 1'b0;
            inv_r <= 1'b0;
            stop_r <= 1'b0;
            act_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            first_ccw_r <= first_ccw_nxt;
            run_req_r <= run_req_nxt;
            inv_r <= inv_nxt;
            stop_r <= stop_nxt;
            act_r <= active;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign run_req = run_req_r;
    assign setpoint_invert = inv_r;
    assign ramp_stop = stop_r;
    assign cmd_active = act_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_cw_entered;
        state_r == TWDC_CW && run_req_r && !inv_r && !stop_r;
    endsequence

    sequence s_stopping;
        state_r == TWDC_STOP && stop_r && !run_req_r;
    endsequence

    property p_src_off;
        !active |=> !run_req_r && !stop_r && !act_r;
    endproperty
    a_src_off: assert property (p_src_off)
        else $error("outputs not idle with other command source");

    property p_m1_stop;
        active && !method2 && !cmd_run |=> stop_r && !run_req_r && !inv_r;
    endproperty
    a_m1_stop: assert property (p_m1_stop)
        else $error("method 1 run low did not ramp stop");

    property p_m1_run;
        active && !method2 && cmd_run |=> run_req_r && (inv_r == $past(cmd_rev));
    endproperty
    a_m1_run: assert property (p_m1_run)
        else $error("method 1 run or reverse wrong");

    property p_m2_start;
        m2_on && state_r == TWDC_IDLE && cw_only |=> s_cw_entered;
    endproperty
    a_m2_start: assert property (p_m2_start)
        else $error("method 2 clockwise start wrong");

    property p_m2_release;
        m2_on && state_r == TWDC_CW && !cmd_run |=> s_stopping;
    endproperty
    a_m2_release: assert property (p_m2_release)
        else $error("method 2 release did not ramp stop");

    property p_m2_hold_stop;
        m2_on && state_r == TWDC_STOP && !at_zero_hz |=> s_stopping;
    endproperty
    a_m2_hold_stop: assert property (p_m2_hold_stop)
        else $error("direction changed before standstill");

    property p_m2_first;
        m2_on && state_r == TWDC_CCW && cmd_ccw |=> state_r == TWDC_CCW && inv_r;
    endproperty
    a_m2_first: assert property (p_m2_first)
        else $error("later command overrode first");

    property p_m2_both_idle;
        m2_on && state_r == TWDC_IDLE && both_on && first_ccw_r |=> state_r == TWDC_CCW;
    endproperty
    a_m2_both_idle: assert property (p_m2_both_idle)
        else $error("first active command not honoured");

    property p_sync;
        din_s2_r == $past(din, 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("input synchroniser depth wrong");

    property p_bus_answer;
        (avs_read || avs_write) && wait_r |=> !wait_r ##1 wait_r;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer timing wrong");
endmodule
`default_nettype wire

// ===== bench/twdc_plant.sv
// Plant switch model driving the digital command inputs.
// Assumes switch levels come from the bench; outputs change after sys_clk edges.
`timescale 1ns/1ns
`default_nettype none
module twdc_plant
(
    input wire logic sys_clk,
    input wire logic [3:0] sw,
    output logic [3:0] din
);
    initial din = 4'h0;
    always @(posedge sys_clk)
    begin
        din <= sw;
    end
endmodule
`default_nettype wire

// ===== bench/test_two_wire_run_direction_control.sv
// Self-checking bench for the two-wire run and direction decoder.
// Assumes twdc_pkg, twdc_top and twdc_plant are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_two_wire_run_direction_control;
    import twdc_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] sw = 4'h0;
    logic [3:0] din;
    logic at_zero_hz = 1'b0;
    logic run_req;
    logic setpoint_invert;
    logic ramp_stop;
    logic cmd_active;
    logic [31:0] rd;
    logic [31:0] fn_exp [4] = '{32'h01, 32'h0C, 32'h00, 32'h00};
    int num_errors = 0;
    int n_compared = 0;
    twdc_top i_twdc_top (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .din(din),
        .at_zero_hz(at_zero_hz), .run_req(run_req), .setpoint_invert(setpoint_invert),
        .ramp_stop(ramp_stop), .cmd_active(cmd_active));
    twdc_plant i_twdc_plant (.sys_clk(sys_clk), .sw(sw), .din(din));
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        // Wait until waitrequest drops; only the watchdog ends a wait that never does
        do
        begin
            @(posedge sys_clk);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic sets(input logic [3:0] v);
        @(posedge sys_clk);
        sw <= v;
    endtask
    // Order: run, invert, ramp stop, active
    task automatic outs(input logic [3:0] e);
        repeat (6) @(posedge sys_clk);
        #1;
        `CHK({run_req, setpoint_invert, ramp_stop, cmd_active}, e)
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #(40 * 5000);
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        rchk(TWDC_OFS_CMD_SRC, 32'h02);
        rchk(TWDC_OFS_WIRE, 32'h00);
        for (int i = 0; i < 4; i++)
            rchk(TWDC_OFS_FN0 + 5'(i * 4), fn_exp[i]);
        bus(1'b1, 5'h0C, 32'hFF);
        rchk(5'h0C, 32'h0);
        $display("test registers done");
        sets(4'b0001);
        outs(4'b1001);
        sets(4'b0011);
        outs(4'b1101);
        sets(4'b0010);
        outs(4'b0011);
        sets(4'b0000);
        outs(4'b0011);
        $display("test method1 done");
        bus(1'b1, TWDC_OFS_FN0, 32'h00);
        bus(1'b1, TWDC_OFS_FN0 + 5'h0C, 32'h01);
        sets(4'b1000);
        outs(4'b1001);
        sets(4'b0001);
        outs(4'b0011);
        sets(4'b0000);
        bus(1'b1, TWDC_OFS_FN0 + 5'h0C, 32'h00);
        bus(1'b1, TWDC_OFS_FN0, 32'h01);
        $display("test remap done");
        bus(1'b1, TWDC_OFS_FN0 + 5'h04, 32'h02);
        sets(4'b0001);
        outs(4'b1001);
        sets(4'b0011);
        outs(4'b1001);
        bus(1'b0, TWDC_OFS_STATUS, 32'h0);
        `CHK(rd[TWDC_FIRST_POS:TWDC_M2_POS], 2'b01)
        `CHK(rd[TWDC_ST_POS +: 4], 4'h2)
        sets(4'b0010);
        outs(4'b0011);
        outs(4'b0011);
        @(posedge sys_clk);
        at_zero_hz <= 1'b1;
        outs(4'b1101);
        @(posedge sys_clk);
        at_zero_hz <= 1'b0;
        sets(4'b0000);
        // Inverted setpoint held while ramping down
        outs(4'b0111);
        @(posedge sys_clk);
        at_zero_hz <= 1'b1;
        outs(4'b0011);
        sets(4'b0011);
        outs(4'b1101);
        @(posedge sys_clk);
        at_zero_hz <= 1'b0;
        $display("test method2 done");
        bus(1'b1, TWDC_OFS_CMD_SRC, 32'h00);
        sets(4'b0001);
        outs(4'b0000);
        bus(1'b1, TWDC_OFS_CMD_SRC, 32'h02);
        bus(1'b1, TWDC_OFS_WIRE, 32'h01);
        outs(4'b0000);
        $display("test source done");
        report_and_stop();
    end
endmodule
`default_nettype wire
